//--- core/alcc_pkg.sv
// Purpose: Shared types and constants for the adaptive logic cell cluster.
// Assumes: Configuration arrives on plain ports and is held steady by the fabric loader.
// Notes: Each cell offers two normal modes and an arithmetic mode with two full adders.
//
// Notes on behaviour
// - Normal mode: two independent 4-input functions, or 5-input plus separate 3-input.
// - Arithmetic mode: four 4-input tables feed two full adders, two tables each.
// - All four arithmetic tables share the same first and second operand inputs.
// - Carry enters lower adder, then upper adder, then next cell's lower adder.
// - Adder sums are available registered, unregistered, or both together.
// - Carry may be used with plain table outputs; the sum is then discarded.
// - Select-larger computes Y plus not X; carry is 1 when X below Y.
// - Comparison carry travels onto cluster routing and drives cluster-wide load select.
// - With load asserted registers take load data (Y), otherwise normal data (X).

package alcc_pkg;

   // ----------------------------------------------------------------
   // Cell operating modes, Gray coded along normal to arithmetic.
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ALCC_MODE_NORM44 = 2'h0,
      ALCC_MODE_NORM53 = 2'h1,
      ALCC_MODE_ARITH = 2'h3
   } alcc_mode_t;

   // ----------------------------------------------------------------
   // Data input positions inside one cell's eight data lines.
   // ----------------------------------------------------------------
   localparam int ALCC_DATAA_BIT = 0;
   localparam int ALCC_DATAB_BIT = 1;
   localparam int ALCC_LO_C_BIT = 2;
   localparam int ALCC_LO_D_BIT = 3;
   localparam int ALCC_HI_C_BIT = 4;
   localparam int ALCC_HI_D_BIT = 5;
   localparam int ALCC_FIVE_WIDTH = 5;
   localparam int ALCC_THREE_LSB = 5;

   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [1:0] ALCC_REG_RST = 2'h0;
   localparam logic ALCC_BIT_RST = 1'h0;

   // ----------------------------------------------------------------
   // Carriers.
   // ----------------------------------------------------------------
   typedef struct packed {
      alcc_mode_t mode;
      logic carry_only;
      logic [3:0][15:0] lut;
   } alcc_cell_cfg_t;

   typedef struct packed {
      logic [1:0] sync_data;
      logic [7:0] data;
   } alcc_cell_in_t;

endpackage

//--- core/alcc_cell.sv
// Purpose: One adaptive logic cell: lookup tables, two full adders, carry pass.
// Assumes: Pure combinational; the cluster holds all registers.
// Notes: Compare mode forces the pre-adder functions to form Y plus not X.
`timescale 1ns/100ps

module alcc_cell
   import alcc_pkg::*;
(
   // Configuration.
   input wire alcc_cell_cfg_t cfg_in,
   input wire logic compare_in,
   // Data and carry.
   input wire logic [7:0] data_in,
   input wire logic carry_in,
   // Results.
   output logic [1:0] out_out,
   output logic carry_out
);

   logic [3:0] idx_lo;
   logic [3:0] idx_hi;
   logic [3:0] pre;
   logic c_mid;
   logic c_top;
   logic s_lo;
   logic s_hi;
   logic [31:0] lut_five;

   // Shared first and second operands feed every arithmetic table.
   assign idx_lo = {data_in[ALCC_LO_D_BIT], data_in[ALCC_LO_C_BIT],
                    data_in[ALCC_DATAB_BIT], data_in[ALCC_DATAA_BIT]};
   assign idx_hi = {data_in[ALCC_HI_D_BIT], data_in[ALCC_HI_C_BIT],
                    data_in[ALCC_DATAB_BIT], data_in[ALCC_DATAA_BIT]};
   assign lut_five = {cfg_in.lut[1], cfg_in.lut[0]};

   // Pre-adder functions, then lower and upper full adders in series.
   always_comb begin
      if (compare_in) begin
         // Y plus inverted X with no carry in leaves a carry only when X is below Y.
         pre = {~data_in[ALCC_HI_C_BIT], data_in[ALCC_HI_D_BIT],
                ~data_in[ALCC_DATAA_BIT], data_in[ALCC_DATAB_BIT]};
      end else begin
         pre = {cfg_in.lut[3][idx_hi], cfg_in.lut[2][idx_hi],
                cfg_in.lut[1][idx_lo], cfg_in.lut[0][idx_lo]};
      end
      s_lo = pre[0] ^ pre[1] ^ carry_in;
      c_mid = (pre[0] & pre[1]) | (carry_in & (pre[0] ^ pre[1]));
      s_hi = pre[2] ^ pre[3] ^ c_mid;
      c_top = (pre[2] & pre[3]) | (c_mid & (pre[2] ^ pre[3]));
   end

   // Output selection per mode.
   always_comb begin
      out_out = ALCC_REG_RST;
      carry_out = carry_in;
      if (compare_in) begin
         // The X bits go on as normal register data; sums are dropped.
         out_out = {data_in[ALCC_HI_C_BIT], data_in[ALCC_DATAA_BIT]};
         carry_out = c_top;
      end else begin
         case (cfg_in.mode)
            ALCC_MODE_NORM44: begin
               out_out = {cfg_in.lut[2][data_in[7:4]], cfg_in.lut[0][data_in[3:0]]};
            end
            ALCC_MODE_NORM53: begin
               out_out = {cfg_in.lut[2][{1'b0, data_in[7:ALCC_THREE_LSB]}],
                          lut_five[data_in[ALCC_FIVE_WIDTH-1:0]]};
            end
            ALCC_MODE_ARITH: begin
               out_out = cfg_in.carry_only ? {pre[2], pre[0]} : {s_hi, s_lo};
               carry_out = c_top;
            end
            default: begin
               out_out = ALCC_REG_RST;
            end
         endcase
      end
   end

endmodule

//--- core/alcc_cluster.sv
// Purpose: Cluster of adaptive logic cells with a ripple carry chain and shared load select.
// Assumes: Configuration ports change only while the cluster is idle.
// Notes: The unregistered view is caught by a port flop; both views share one edge.
`timescale 1ns/100ps

module alcc_cluster
   import alcc_pkg::*;
#(
   parameter int NUM_CELLS = 8
)
(
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Configuration.
   input wire alcc_cell_cfg_t [NUM_CELLS-1:0] cell_cfg_in,
   input wire logic compare_mode_in,
   // Cell data, chain carry and external load select.
   input wire alcc_cell_in_t [NUM_CELLS-1:0] cell_data_in,
   input wire logic carry_in_in,
   input wire logic syncload_in,
   // Results.
   output logic [NUM_CELLS-1:0][1:0] comb_out,
   output logic [NUM_CELLS-1:0][1:0] reg_out,
   output logic carry_out_out,
   output logic syncload_out
);

   // ----------------------------------------------------------------
   // Parameter check.
   // ----------------------------------------------------------------
   if (NUM_CELLS < 1 || NUM_CELLS > 16) begin : g_bad_cells
      $error("NUM_CELLS must lie between 1 and 16");
   end

   typedef struct packed {
      logic [NUM_CELLS-1:0][1:0] cell_reg;
      logic [NUM_CELLS-1:0][1:0] comb;
      logic carry;
      logic sload;
   } alcc_state_t;

   alcc_state_t state_q;
   alcc_state_t state_d;
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [NUM_CELLS:0] chain;
   logic [NUM_CELLS-1:0][1:0] cell_out;
   logic sload;

   // ----------------------------------------------------------------
   // Reset release through two flops.
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------------------------------
   // Cells and carry chain.
   // ----------------------------------------------------------------
   // A comparison starts with no carry so the chain forms Y plus not X.
   assign chain[0] = compare_mode_in ? 1'b0 : carry_in_in;

   // Each upper carry feeds the next cell's lower adder.
   for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
      alcc_cell u_cell (
         .cfg_in(cell_cfg_in[i]),
         .compare_in(compare_mode_in),
         .data_in(cell_data_in[i].data),
         .carry_in(chain[i]),
         .out_out(cell_out[i]),
         .carry_out(chain[i+1])
      );
   end

   // The chain carry drives the load select directly in compare mode.
   assign sload = compare_mode_in ? chain[NUM_CELLS] : syncload_in;

   // ----------------------------------------------------------------
   // Next state: every register sees the same load select.
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      state_d.comb = cell_out;
      state_d.carry = chain[NUM_CELLS];
      state_d.sload = sload;
      for (int i = 0; i < NUM_CELLS; i++) begin
         // Load data wins while the select is high, on this same edge.
         state_d.cell_reg[i] = sload ? cell_data_in[i].sync_data : cell_out[i];
      end
   end

   // State register.
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs straight from flops.
   assign comb_out = state_q.comb;
   assign reg_out = state_q.cell_reg;
   assign carry_out_out = state_q.carry;
   assign syncload_out = state_q.sload;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   logic [2*NUM_CELLS-1:0] x_val;
   logic [2*NUM_CELLS-1:0] y_val;
   logic [3:0] ref_lo;
   logic [3:0] ref_hi;
   logic [31:0] ref_five;
   logic [NUM_CELLS-1:0][1:0] sync_all;
   logic chk_armed_q;

   // Operand words assembled from the cell inputs, lower bit first per cell.
   for (genvar i = 0; i < NUM_CELLS; i++) begin : g_ops
      assign x_val[2*i] = cell_data_in[i].data[ALCC_DATAA_BIT];
      assign x_val[2*i+1] = cell_data_in[i].data[ALCC_HI_C_BIT];
      assign y_val[2*i] = cell_data_in[i].data[ALCC_DATAB_BIT];
      assign y_val[2*i+1] = cell_data_in[i].data[ALCC_HI_D_BIT];
      assign sync_all[i] = cell_data_in[i].sync_data;
   end
   assign ref_lo = cell_data_in[0].data[3:0];
   assign ref_hi = {cell_data_in[0].data[5:4], cell_data_in[0].data[1:0]};
   assign ref_five = {cell_cfg_in[0].lut[1], cell_cfg_in[0].lut[0]};

   // Holds the checks off until the first edge whose state follows sampled inputs.
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         chk_armed_q <= 1'b0;
      end else begin
         chk_armed_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!chk_armed_q);

   norm_split_a: assert property (
      !$past(compare_mode_in) && $past(cell_cfg_in[0].mode) == ALCC_MODE_NORM44
      |-> comb_out[0] == $past({cell_cfg_in[0].lut[2][cell_data_in[0].data[7:4]],
                                cell_cfg_in[0].lut[0][ref_lo]}))
      else $error("normal split output wrong");

   norm_five_a: assert property (
      !$past(compare_mode_in) && $past(cell_cfg_in[0].mode) == ALCC_MODE_NORM53
      |-> comb_out[0][0] == $past(ref_five[cell_data_in[0].data[4:0]]))
      else $error("five-input output wrong");

   arith_sum_a: assert property (
      !$past(compare_mode_in) && $past(cell_cfg_in[0].mode) == ALCC_MODE_ARITH
      && !$past(cell_cfg_in[0].carry_only)
      |-> comb_out[0][0] == $past(cell_cfg_in[0].lut[0][ref_lo]
                                  ^ cell_cfg_in[0].lut[1][ref_lo] ^ carry_in_in))
      else $error("lower adder sum wrong");

   shared_ops_a: assert property (
      !$past(compare_mode_in) && $past(cell_cfg_in[0].mode) == ALCC_MODE_ARITH
      && $past(cell_cfg_in[0].carry_only)
      |-> comb_out[0] == $past({cell_cfg_in[0].lut[2][ref_hi], cell_cfg_in[0].lut[0][ref_lo]}))
      else $error("table outputs do not follow shared operands");

   cmp_carry_a: assert property (
      compare_mode_in |=> syncload_out == $past(x_val < y_val))
      else $error("comparison carry wrong");

   carry_route_a: assert property (
      $past(compare_mode_in) |-> syncload_out == carry_out_out)
      else $error("load select not taken from chain carry");

   load_pick_a: assert property (
      syncload_out |-> reg_out == $past(sync_all))
      else $error("load data not captured");

   both_views_a: assert property (
      !syncload_out |-> reg_out == comb_out)
      else $error("registered and unregistered views differ");

   same_edge_a: assert property (
      $rose(syncload_out) |-> reg_out[NUM_CELLS-1] == $past(cell_data_in[NUM_CELLS-1].sync_data)
      && reg_out[0] == $past(cell_data_in[0].sync_data))
      else $error("load select late or not uniform");

   cover_cmp_c: cover property (compare_mode_in ##1 syncload_out);
   cover_arith_c: cover property (cell_cfg_in[0].mode == ALCC_MODE_ARITH ##1 carry_out_out);
   cover_five_c: cover property (cell_cfg_in[0].mode == ALCC_MODE_NORM53 ##1 comb_out[0][0]);

endmodule

//--- tb/alcc_neighbour.sv
// Purpose: Neighbour cell and cluster routing in front of the cluster's chain input.
// Assumes: Requests from the bench change just after a rising edge.
// Notes: Routing adds no delay, so lines follow requests at once.
`timescale 1ns/100ps

module alcc_neighbour (
   // Requests from the bench.
   input wire logic carry_req_in,
   input wire logic load_req_in,
   // Lines into the cluster.
   output logic carry_out,
   output logic syncload_out
);
   // ----------------------------------------------------------------
   // Routing
   // ----------------------------------------------------------------
   // The previous cell's upper carry feeds the first lower adder here.
   assign carry_out = carry_req_in;
   // A cluster control line carries an outside load select.
   assign syncload_out = load_req_in;
endmodule

//--- tb/logic_cell_arithmetic_mode_bench.sv
// Purpose: Self-checking bench for a two-cell cluster.
// Assumes: Outputs show the inputs of the previous edge.
// Notes: Operand bit 2i sits on d0 and d1 of cell i, bit 2i+1 on d4 and d5.
`timescale 1ns/100ps

module logic_cell_arithmetic_mode_bench;
   import alcc_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int NC = 2;
   typedef struct packed {
      logic cmp;
      logic [3:0] x;
      logic [3:0] y;
      logic cin;
      logic sl;
   } alcc_row_t;
   logic clock_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic compare_mode_in = 1'h0;
   logic carry_req = 1'h0;
   logic load_req = 1'h0;
   logic carry_w;
   logic sync_w;
   alcc_cell_cfg_t [NC-1:0] cfg = '0;
   alcc_cell_in_t [NC-1:0] din = '0;
   logic [NC-1:0][1:0] comb_o;
   logic [NC-1:0][1:0] reg_o;
   logic cout;
   logic slo;
   int err_total = 0;
   int n_checks = 0;
   alcc_row_t rows [10] = '{'{1'h1, 4'h3, 4'h5, 1'h0, 1'h0}, '{1'h1, 4'h5, 4'h3, 1'h0, 1'h0},
      '{1'h1, 4'h7, 4'h7, 1'h1, 1'h0}, '{1'h1, 4'h0, 4'hf, 1'h0, 1'h0},
      '{1'h1, 4'hf, 4'h0, 1'h0, 1'h0}, '{1'h0, 4'hf, 4'h1, 1'h0, 1'h0},
      '{1'h0, 4'h7, 4'h8, 1'h1, 1'h0}, '{1'h0, 4'h0, 4'h0, 1'h1, 1'h0},
      '{1'h0, 4'ha, 4'h5, 1'h0, 1'h1}, '{1'h0, 4'h9, 4'h6, 1'h0, 1'h0}};

   // Clock at 25 MHz.
   always #20 clock_in = ~clock_in;

   // Far-side routing and the cluster under test.
   alcc_neighbour i_alcc_neighbour (.carry_req_in(carry_req), .load_req_in(load_req),
      .carry_out(carry_w), .syncload_out(sync_w));
   alcc_cluster #(.NUM_CELLS(NC)) i_alcc_cluster (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .cell_cfg_in(cfg), .compare_mode_in(compare_mode_in), .cell_data_in(din),
      .carry_in_in(carry_w), .syncload_in(sync_w), .comb_out(comb_o), .reg_out(reg_o),
      .carry_out_out(cout), .syncload_out(slo));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compares a four-bit result.
   task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Compares a one-bit result.
   task automatic chk_bit(input logic got, input logic exp);
      chk_vec({3'h0, got}, {3'h0, exp});
   endtask

   // Sets every cell to one configuration.
   task automatic set_cfg(input alcc_mode_t m, input logic co, input logic [63:0] l);
      for (int i = 0; i < NC; i++) begin
         cfg[i] = {m, co, l};
      end
   endtask

   // Spreads two operands over the cells; load data carries Y.
   task automatic put(input logic [3:0] x, input logic [3:0] y);
      for (int i = 0; i < NC; i++) begin
         din[i].data = {2'h0, y[2*i+1], x[2*i+1], 2'h0, y[2*i], x[2*i]};
         din[i].sync_data = {y[2*i+1], y[2*i]};
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic conclude;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Waits one edge and lets its updates land.
   task automatic step;
      @(posedge clock_in);
      #1;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   // Resets, runs the row table, then the hand-written cases.
   initial begin
      logic [4:0] s;
      logic lt;
      repeat (4) @(posedge clock_in);
      #1 rst_n_in = 1'h1;
      repeat (3) step();
      chk_vec(reg_o, 4'h0);
      // Lower tables pass d0 and d1, upper tables d4 and d5.
      set_cfg(ALCC_MODE_ARITH, 1'h0, {16'hff00, 16'hf0f0, 16'hcccc, 16'haaaa});
      foreach (rows[k]) begin
         compare_mode_in = rows[k].cmp;
         carry_req = rows[k].cin;
         load_req = rows[k].sl;
         put(rows[k].x, rows[k].y);
         step();
         s = rows[k].x + rows[k].y + rows[k].cin;
         lt = rows[k].x < rows[k].y;
         if (rows[k].cmp) begin
            chk_bit(cout, lt);
            chk_bit(slo, lt);
            chk_vec(reg_o, lt ? rows[k].y : rows[k].x);
            chk_vec(comb_o, rows[k].x);
         end else begin
            chk_vec(comb_o, s[3:0]);
            chk_bit(cout, s[4]);
            chk_vec(reg_o, rows[k].sl ? rows[k].y : s[3:0]);
         end
      end
      // Carry beside plain table outputs; upper tables also read d0 and d1.
      compare_mode_in = 1'h0;
      load_req = 1'h0;
      carry_req = 1'h0;
      set_cfg(ALCC_MODE_ARITH, 1'h1, {16'hcccc, 16'haaaa, 16'hcccc, 16'haaaa});
      put(4'h5, 4'hc);
      step();
      chk_vec(comb_o, 4'hf);
      chk_bit(cout, 1'h1);
      // Both normal splits on one data set; table outputs, both views equal.
      din[0].data = 8'h91;
      din[1].data = 8'h6e;
      set_cfg(ALCC_MODE_NORM44, 1'h0, {16'h0, 16'hff00, 16'h0, 16'haaaa});
      step();
      chk_vec(comb_o, 4'h3);
      set_cfg(ALCC_MODE_NORM53, 1'h0, {16'h0, 16'h00f0, 16'hffff, 16'h0});
      step();
      chk_vec(comb_o, 4'h3);
      chk_vec(reg_o, 4'h3);
      // Reset in mid-run clears the upper cell's registered pair, the load select and the carry.
      rst_n_in = 1'h0;
      repeat (2) step();
      chk_vec({reg_o[1], slo, cout}, 4'h0);
      rst_n_in = 1'h1;
      repeat (3) step();
      chk_vec(reg_o, 4'h3);
      conclude();
   end

   // Cuts a hang short.
   initial begin
      repeat (2000) @(posedge clock_in);
      err_total++;
      conclude();
   end
endmodule
